/* File: pkg/prd_pkg.sv */
// Constants for the PLL ratio and divider control block
// Functional notes
// - Receiver enabled puts the PLL under the receiver's automatic control.
// - Receiver disabled: multiplier, fraction and dividers come from host registers.
// - Automatic mode: derived clocks follow the recovered incoming sample rate.
// - After a rate change clocks keep running but are invalid until relock.
// - Stream stopped in automatic mode: integer and fraction values stay frozen.
// - Power-up without a stream defaults the PLL near 24 MHz.
// - Fraction is 22 bits over three byte registers, top six in bits 5:0.
// - Integer multiplier is bits 3:0 of the register at offset six.
// - Ratio is integer plus fraction over two to the twenty-second, added.
// - Bit 4 of offset six halves the oscillator input when set; reset zero.
// - Two-bit post-divider select in bits 1:0 of offset seven, reset binary 10.
// - In automatic mode the device sets the post-divider select itself.
// - Bit 2 of offset seven enables fractional operation; forced on while receiving.
package prd_pkg;

  localparam int ADDR_W = 7;
  localparam int FRAC_W = 22;
  localparam int INT_W  = 4;

  localparam logic [6:0] FRAC_LOW_OFFSET   = 7'h03;
  localparam logic [6:0] FRAC_MID_OFFSET   = 7'h04;
  localparam logic [6:0] FRAC_HIGH_OFFSET  = 7'h05;
  localparam logic [6:0] INT_INDIV_OFFSET  = 7'h06;
  localparam logic [6:0] OUT_DIV_OFFSET    = 7'h07;
  localparam logic [6:0] STATUS_OFFSET     = 7'h0c;

  // Reset values give a ratio near 7.86, about 24 MHz after the default divider
  localparam logic [7:0] FRAC_LOW_RESET    = 8'h21;
  localparam logic [7:0] FRAC_MID_RESET    = 8'hfd;
  localparam logic [5:0] FRAC_HIGH_RESET   = 6'h36;
  localparam logic [3:0] INT_RESET         = 4'h7;
  localparam logic       HALVER_RESET      = 1'b0;
  localparam logic [1:0] POST_DIV_RESET    = 2'b10;
  localparam logic       FRAC_EN_RESET     = 1'b1;
  localparam logic       MCLK_HALVE_RESET  = 1'b0;

  localparam int FRAC_HIGH_MSB   = 5;
  localparam int INT_MSB         = 3;
  localparam int HALVER_BIT      = 4;
  localparam int POST_DIV_MSB    = 1;
  localparam int FRAC_EN_BIT     = 2;
  localparam int MCLK_HALVE_BIT  = 3;

  localparam int STAT_AUTO_BIT   = 0;
  localparam int STAT_VALID_BIT  = 1;
  localparam int STAT_FROZEN_BIT = 2;
  localparam int STAT_RELOCK_BIT = 3;

endpackage

/* File: rtl/prd_ratio_ctrl.sv */
// PLL ratio, pre-scaler and post-divider control with automatic and manual modes
`timescale 1ns/10ps
`default_nettype none

module prd_ratio_ctrl
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic [6:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [7:0]  reg_rdata,
  input  wire logic        rx_enable,
  input  wire logic        rx_stream_present,
  input  wire logic        rx_locked,
  input  wire logic        rx_rate_change,
  input  wire logic        rx_ratio_load,
  input  wire logic [3:0]  rx_int_mult,
  input  wire logic [21:0] rx_frac_word,
  input  wire logic [1:0]  rx_post_div,
  output var  logic        auto_mode,
  output var  logic [3:0]  pll_int_mult,
  output var  logic [21:0] pll_frac_word,
  output var  logic        fractional_loop_enable,
  output var  logic [25:0] pll_ratio,
  output var  logic        pll_input_halver,
  output var  logic [1:0]  pll_post_divider_select,
  output var  logic        master_clock_halve_select,
  output var  logic        clocks_valid
);

  // ****************************************
  // Host register file
  // ****************************************
  logic [7:0] frac_low_reg;
  logic [7:0] frac_mid_reg;
  logic [5:0] frac_high_reg;
  logic [3:0] int_reg;
  logic       halver_reg;
  logic [1:0] post_div_reg;
  logic       frac_en_reg;
  logic       mclk_halve_reg;
  logic       relock_wait_reg;
  logic [3:0] auto_int_reg;
  logic [21:0] auto_frac_reg;
  logic [1:0] auto_post_reg;
  logic       auto_prev_reg;
  logic [7:0] rdata_next;
  logic [3:0] int_next;
  logic [21:0] frac_next;
  logic       frac_en_next;
  logic [1:0] post_next;
  logic       frozen;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      frac_low_reg   <= prd_pkg::FRAC_LOW_RESET;
      frac_mid_reg   <= prd_pkg::FRAC_MID_RESET;
      frac_high_reg  <= prd_pkg::FRAC_HIGH_RESET;
      int_reg        <= prd_pkg::INT_RESET;
      halver_reg     <= prd_pkg::HALVER_RESET;
      post_div_reg   <= prd_pkg::POST_DIV_RESET;
      frac_en_reg    <= prd_pkg::FRAC_EN_RESET;
      mclk_halve_reg <= prd_pkg::MCLK_HALVE_RESET;
    end
    else if (clk_en && reg_wr)
    begin
      // Each write touches only its own register in either mode
      unique case (reg_addr)
        prd_pkg::FRAC_LOW_OFFSET:  frac_low_reg <= reg_wdata;
        prd_pkg::FRAC_MID_OFFSET:  frac_mid_reg <= reg_wdata;
        prd_pkg::FRAC_HIGH_OFFSET: frac_high_reg <= reg_wdata[prd_pkg::FRAC_HIGH_MSB:0];
        prd_pkg::INT_INDIV_OFFSET:
        begin
          int_reg    <= reg_wdata[prd_pkg::INT_MSB:0];
          halver_reg <= reg_wdata[prd_pkg::HALVER_BIT];
        end
        prd_pkg::OUT_DIV_OFFSET:
        begin
          post_div_reg   <= reg_wdata[prd_pkg::POST_DIV_MSB:0];
          frac_en_reg    <= reg_wdata[prd_pkg::FRAC_EN_BIT];
          mclk_halve_reg <= reg_wdata[prd_pkg::MCLK_HALVE_BIT];
        end
        default:
        begin
        end
      endcase
    end
  end

  // ****************************************
  // Automatic mode steering
  // ****************************************
  assign frozen = rx_enable && !rx_stream_present;

  // Entry into automatic mode seeds from host values, then the receiver steers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      auto_int_reg  <= prd_pkg::INT_RESET;
      auto_frac_reg <= {prd_pkg::FRAC_HIGH_RESET, prd_pkg::FRAC_MID_RESET,
                        prd_pkg::FRAC_LOW_RESET};
      auto_post_reg <= prd_pkg::POST_DIV_RESET;
      auto_prev_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      auto_prev_reg <= rx_enable;
      if (rx_enable && !auto_prev_reg)
      begin
        auto_int_reg  <= int_reg;
        auto_frac_reg <= {frac_high_reg, frac_mid_reg, frac_low_reg};
        auto_post_reg <= post_div_reg;
      end
      else if (rx_enable && rx_ratio_load && !frozen)
      begin
        // A load with no stream is ignored so the last rate is kept
        auto_int_reg  <= rx_int_mult;
        auto_frac_reg <= rx_frac_word;
        auto_post_reg <= rx_post_div;
      end
    end
  end

  // Set by a rate change wins over a clear from lock in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      relock_wait_reg <= 1'b0;
    else if (clk_en)
    begin
      if (rx_enable && rx_rate_change)
        relock_wait_reg <= 1'b1;
      else if (!rx_enable || rx_locked)
        relock_wait_reg <= 1'b0;
    end
  end

  // ****************************************
  // Effective PLL settings
  // ****************************************
  always_comb
  begin
    if (rx_enable && auto_prev_reg)
    begin
      int_next     = auto_int_reg;
      frac_next    = auto_frac_reg;
      frac_en_next = 1'b1;
      post_next    = auto_post_reg;
    end
    else
    begin
      int_next     = int_reg;
      frac_next    = {frac_high_reg, frac_mid_reg, frac_low_reg};
      frac_en_next = frac_en_reg;
      post_next    = post_div_reg;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      auto_mode                 <= 1'b0;
      pll_int_mult              <= prd_pkg::INT_RESET;
      pll_frac_word             <= {prd_pkg::FRAC_HIGH_RESET, prd_pkg::FRAC_MID_RESET,
                                    prd_pkg::FRAC_LOW_RESET};
      fractional_loop_enable    <= prd_pkg::FRAC_EN_RESET;
      pll_ratio                 <= {prd_pkg::INT_RESET, prd_pkg::FRAC_HIGH_RESET,
                                    prd_pkg::FRAC_MID_RESET, prd_pkg::FRAC_LOW_RESET};
      pll_input_halver          <= prd_pkg::HALVER_RESET;
      pll_post_divider_select   <= prd_pkg::POST_DIV_RESET;
      master_clock_halve_select <= prd_pkg::MCLK_HALVE_RESET;
      clocks_valid              <= 1'b1;
    end
    else if (clk_en)
    begin
      auto_mode                 <= rx_enable && auto_prev_reg;
      pll_int_mult              <= int_next;
      pll_frac_word             <= frac_next;
      fractional_loop_enable    <= frac_en_next;
      // Fixed point with 22 fraction bits: integer and fraction add; fraction is zero while fractional operation is off
      pll_ratio                 <= {int_next, frac_en_next ? frac_next : 22'h000000};
      pll_input_halver          <= halver_reg;
      pll_post_divider_select   <= post_next;
      master_clock_halve_select <= mclk_halve_reg;
      clocks_valid              <= !rx_enable || (rx_locked && !relock_wait_reg
                                   && !(rx_rate_change)) || frozen;
    end
  end

  // ****************************************
  // Read back
  // ****************************************
  always_comb
  begin
    rdata_next = 8'h00;
    unique case (reg_addr)
      prd_pkg::FRAC_LOW_OFFSET:  rdata_next = frac_low_reg;
      prd_pkg::FRAC_MID_OFFSET:  rdata_next = frac_mid_reg;
      prd_pkg::FRAC_HIGH_OFFSET: rdata_next = {2'b00, frac_high_reg};
      prd_pkg::INT_INDIV_OFFSET: rdata_next = {3'b000, halver_reg, int_reg};
      prd_pkg::OUT_DIV_OFFSET:   rdata_next = {4'h0, mclk_halve_reg, frac_en_reg, post_div_reg};
      prd_pkg::STATUS_OFFSET:
      begin
        rdata_next[prd_pkg::STAT_AUTO_BIT]   = auto_mode;
        rdata_next[prd_pkg::STAT_VALID_BIT]  = clocks_valid;
        rdata_next[prd_pkg::STAT_FROZEN_BIT] = frozen;
        rdata_next[prd_pkg::STAT_RELOCK_BIT] = relock_wait_reg;
      end
      default:                   rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (clk_en && reg_rd)
      reg_rdata <= rdata_next;
  end

endmodule

`default_nettype wire

/* File: dv/prd_ratio_ctrl_assertions.sv */
// Concurrent checks on the ports of the PLL ratio and divider control block
`timescale 1ns/10ps
`default_nettype none
module prd_ratio_ctrl_assertions
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic [6:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        rx_enable,
  input wire logic        rx_stream_present,
  input wire logic        rx_rate_change,
  input wire logic        rx_ratio_load,
  input wire logic [3:0]  rx_int_mult,
  input wire logic [21:0] rx_frac_word,
  input wire logic [1:0]  rx_post_div,
  input wire logic        auto_mode,
  input wire logic [3:0]  pll_int_mult,
  input wire logic [21:0] pll_frac_word,
  input wire logic        fractional_loop_enable,
  input wire logic [25:0] pll_ratio,
  input wire logic        pll_input_halver,
  input wire logic [1:0]  pll_post_divider_select,
  input wire logic        clocks_valid
);
  // Stalled cycles freeze all state, so they are left unchecked
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || !clk_en);
  // ****************
  // Mode and ratio
  // ****************
  property p_auto_entry; rx_enable[*2] |=> auto_mode; endproperty
  a_auto_entry: assert property (p_auto_entry) else $error("auto mode missing");
  property p_manual; !rx_enable[*2] |=> !auto_mode; endproperty
  a_manual: assert property (p_manual) else $error("auto mode stuck");
  property p_frac_forced; auto_mode |-> fractional_loop_enable; endproperty
  a_frac_forced: assert property (p_frac_forced) else $error("fraction off in auto");
  property p_ratio;
    pll_ratio == {pll_int_mult, fractional_loop_enable ? pll_frac_word : 22'h0};
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio not int plus fraction");
  property p_steer;
    rx_ratio_load && rx_enable && auto_mode && rx_stream_present ##1 rx_enable |=>
      pll_int_mult == $past(rx_int_mult, 2) && pll_frac_word == $past(rx_frac_word, 2)
      && pll_post_divider_select == $past(rx_post_div, 2);
  endproperty
  a_steer: assert property (p_steer) else $error("steered values not applied");
  property p_freeze;
    (rx_enable && !rx_stream_present)[*3] |=> $stable(pll_int_mult) && $stable(pll_frac_word);
  endproperty
  a_freeze: assert property (p_freeze) else $error("ratio moved without stream");
  property p_rate; rx_rate_change && rx_enable && rx_stream_present |=> !clocks_valid; endproperty
  a_rate: assert property (p_rate) else $error("clocks valid after rate change");
  property p_host_int;
    reg_wr && reg_addr == 7'h06 && !rx_enable && !auto_mode ##1
      !rx_enable && !(reg_wr && reg_addr == 7'h06) |=>
      pll_int_mult == $past(reg_wdata[3:0], 2) && pll_input_halver == $past(reg_wdata[4], 2);
  endproperty
  a_host_int: assert property (p_host_int) else $error("integer write lost");
  property p_host_post;
    reg_wr && reg_addr == 7'h07 && !rx_enable && !auto_mode ##1
      !rx_enable && !(reg_wr && reg_addr == 7'h07) |=>
      pll_post_divider_select == $past(reg_wdata[1:0], 2);
  endproperty
  a_host_post: assert property (p_host_post) else $error("post divider write lost");
  c_auto: cover property ($rose(auto_mode));
  c_frozen: cover property (auto_mode && !rx_stream_present);
  c_invalid: cover property ($fell(clocks_valid));
endmodule
bind prd_ratio_ctrl prd_ratio_ctrl_assertions prd_ratio_ctrl_assertions_i (.*);
`default_nettype wire

/* File: dv/prd_rx_model.sv */
// Behavioural model of the receiver that steers the PLL
`timescale 1ns/10ps
`default_nettype none
module prd_rx_model
(
  input  wire logic        clk_sys,
  output var  logic        rx_enable,
  output var  logic        rx_stream_present,
  output var  logic        rx_locked,
  output var  logic        rx_rate_change,
  output var  logic        rx_ratio_load,
  output var  logic [3:0]  rx_int_mult,
  output var  logic [21:0] rx_frac_word,
  output var  logic [1:0]  rx_post_div
);
  initial
  begin
    {rx_enable, rx_stream_present, rx_locked, rx_rate_change, rx_ratio_load} = 5'h00;
    {rx_int_mult, rx_frac_word, rx_post_div} = 28'h0;
  end
  task automatic set(input logic en, input logic strm);
    @(negedge clk_sys);
    {rx_enable, rx_stream_present, rx_locked} = {en, strm, strm};
  endtask
  // Settings are only meaningful under the strobe, so they are inverted after it
  task automatic load(input logic [3:0] n, input logic [21:0] k, input logic [1:0] pd);
    @(negedge clk_sys);
    {rx_int_mult, rx_frac_word, rx_post_div, rx_ratio_load} = {n, k, pd, 1'b1};
    @(negedge clk_sys);
    {rx_int_mult, rx_frac_word, rx_post_div, rx_ratio_load} = {~{n, k, pd}, 1'b0};
  endtask
  // Lock is lost for a chosen span, so relock can be prompt or slow
  task automatic new_rate(input int lock_wait);
    @(negedge clk_sys);
    {rx_rate_change, rx_locked} = 2'b10;
    @(negedge clk_sys);
    rx_rate_change = 1'b0;
    repeat (lock_wait) @(negedge clk_sys);
    rx_locked = 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: dv/prd_ratio_ctrl_tb_top.sv */
// Self-checking testbench for the PLL ratio and divider control block
`timescale 1ns/10ps
`default_nettype none
module prd_ratio_ctrl_tb_top;
  logic        clk_sys, rst, reg_wr, reg_rd;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic        rx_enable, rx_stream_present, rx_locked, rx_rate_change, rx_ratio_load;
  logic [3:0]  rx_int_mult, pll_int_mult;
  logic [21:0] rx_frac_word;
  logic [1:0]  rx_post_div, pll_post_divider_select;
  logic        auto_mode, fractional_loop_enable, pll_input_halver, clocks_valid;
  logic        clk_en, master_clock_halve_select;
  logic [25:0] pll_ratio;
  int          error_cnt = 0;
  int          compares = 0;
  logic [7:0]  rst_tab [5] = '{8'h21, 8'hfd, 8'h36, 8'h07, 8'h06};
  logic [7:0]  man_tab [5] = '{8'hba, 8'h49, 8'hcc, 8'h18, 8'h0d};
  prd_ratio_ctrl prd_ratio_ctrl_i (.*, .pll_frac_word());
  prd_rx_model prd_rx_model_i (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [25:0] got, input logic [25:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk(26'(reg_rdata), 26'(exp), "read data");
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    error_cnt++;
    wrap_up();
  end
  // ****************
  // Tests
  // ****************
  initial
  begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h4, 15'h0};
    clk_en = 1'b1;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    for (int i = 0; i < 5; i++) rdc(7'(i + 3), rst_tab[i]);
    rdc(7'h00, 8'h00);
    chk(pll_ratio, {4'h7, 22'h36fd21}, "reset ratio");
    $display("test reset done");
    for (int i = 0; i < 5; i++) wr(7'(i + 3), man_tab[i]);
    repeat (2) @(negedge clk_sys);
    chk(pll_ratio, {4'h8, 22'h0c49ba}, "manual ratio");
    chk(26'({master_clock_halve_select, pll_input_halver, pll_post_divider_select}), 26'hd,
        "dividers");
    rdc(7'h05, 8'h0c);
    wr(7'h07, 8'h01);
    repeat (2) @(negedge clk_sys);
    chk(pll_ratio, {4'h8, 22'h0}, "integer ratio");
    rdc(7'h0c, 8'h02);
    // A write while the clock enable is low must leave every register alone
    clk_en = 1'b0;
    wr(7'h06, 8'h1f);
    clk_en = 1'b1;
    rdc(7'h06, 8'h18);
    chk(26'(pll_int_mult), 26'h8, "stalled write");
    $display("test manual done");
    prd_rx_model_i.set(1'b1, 1'b1);
    repeat (3) @(negedge clk_sys);
    chk(26'({auto_mode, fractional_loop_enable}), 26'h3, "auto entry");
    prd_rx_model_i.load(4'h7, 22'h21b089, 2'b01);
    repeat (2) @(negedge clk_sys);
    chk(pll_ratio, {4'h7, 22'h21b089}, "steered ratio");
    wr(7'h07, 8'h02);
    repeat (2) @(negedge clk_sys);
    chk(26'({fractional_loop_enable, pll_post_divider_select}), 26'h5, "steered");
    rdc(7'h07, 8'h02);
    prd_rx_model_i.new_rate(4);
    chk(26'(clocks_valid), 26'h0, "valid before relock");
    for (int i = 0; i < 8 && clocks_valid !== 1'b1; i++) @(negedge clk_sys);
    chk(26'(clocks_valid), 26'h1, "valid after relock");
    $display("test auto done");
    prd_rx_model_i.set(1'b1, 1'b0);
    prd_rx_model_i.load(4'h9, 22'h000123, 2'b11);
    repeat (3) @(negedge clk_sys);
    chk(pll_ratio, {4'h7, 22'h21b089}, "frozen ratio");
    rdc(7'h0c, 8'h07);
    prd_rx_model_i.set(1'b0, 1'b0);
    repeat (3) @(negedge clk_sys);
    chk(pll_ratio, {4'h8, 22'h0}, "host ratio back");
    chk(26'({auto_mode, pll_post_divider_select}), 26'h2, "host mode back");
    $display("test freeze done");
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    chk(pll_ratio, {4'h7, 22'h36fd21}, "ratio after reset");
    rdc(7'h07, 8'h06);
    rdc(7'h03, 8'h21);
    $display("test reset again done");
    wrap_up();
  end
endmodule
`default_nettype wire
